// ==== inc/fsp_defs.vh ====
// Purpose: Constants for the flash serial programming port.
// Assumes: Included by bare name; 20 MHz system clock.
// Notes:   Boot area bound and blank value are plain macros, not parameters.
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
`define FSP_UNIT_BITS        4'h8
`define FSP_BIT_CNT_W        3
`define FSP_ID_BYTES         3'h7
`define FSP_ID_IDX_W         3
`define FSP_RESET_HOLD_CYC   5'h14
`define FSP_BLANK_BYTE       8'hFF
`define FSP_BOOT_AREA_HI     8'hFF
`define FSP_MODE_NORMAL      2'h1
`define FSP_MODE_SERIAL      2'h2
`define FSP_MODE_IDLE        2'h0
`define FSP_LAST_BIT         3'h7
`endif

// ==== rtl/fsp_id_store.v ====
// Purpose: Seven-byte identification code store with registered read data.
// Assumes: Loaded by the on-chip processor through the write port.
// Notes:   Read data appear one cycle after the address.
`include "fsp_defs.vh"
module fsp_id_store (
    input  wire       clock,
    input  wire       wr_en,
    input  wire [2:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [2:0] rd_addr,
    output reg  [7:0] rd_data
);
    reg [7:0] mem [0:6];
    always @(posedge clock) begin
        if (wr_en && wr_addr < `FSP_ID_BYTES) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_addr < `FSP_ID_BYTES) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= `FSP_BLANK_BYTE;
        end
    end
endmodule // fsp_id_store

// ==== rtl/fsp_serial_port.v ====
// Behaviour
// - Serial mode entered only if reset released with chip enable high, select low, mode high.
// - Processor-mode pin low at release selects normal operation.
// - Traffic uses only transfer clock, receive, transmit and busy signals.
// - Transfer clock comes from the programmer; device only samples it.
// - Busy goes low when ready to receive, high when reception starts.
// - Data move in units of eight bits.
// - Rewrites of the boot area are refused; user area only. The code refuses them in serial mode only; other modes grant them.
// - A seven-byte identification code is held for command gating.
// - Non-blank flash with mismatched code rejects programmer commands.
// - Rewrite is done by the on-chip processor from received data.
// - Mode unavailable when the boot control program is missing.
// - Receive sampled on rising transfer clock, transmit shifted on falling.
// - Bytes travel least significant bit first.
// - Busy held high through transfers and execution.
// Purpose: Serial programming link front end and entry logic.
// Assumes: Pins are asynchronous to clock; processor side is on clock.
// Notes:   Transfer clock is oversampled, so it must be well below clock/4.
`include "fsp_defs.vh"
module fsp_serial_port (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       chip_enable_in,
    input  wire       program_mode_select_in,
    input  wire       processor_mode_pin,
    input  wire       boot_program_valid,
    input  wire       flash_blank,
    input  wire       transfer_clock_in,
    input  wire       serial_receive_in,
    output reg        serial_transmit_out,
    output reg        serial_busy_out,
    output reg        serial_mode_active,
    output reg        normal_mode_active,
    output reg        reset_hold_short,
    output reg  [7:0] rx_byte,
    output reg        rx_byte_valid,
    output reg        rx_is_id,
    output reg        cmd_rejected,
    output reg        id_matched,
    input  wire       id_check_start,
    input  wire       id_wr_en,
    input  wire [2:0] id_wr_addr,
    input  wire [7:0] id_wr_data,
    input  wire [7:0] tx_byte,
    input  wire       tx_load,
    input  wire       exec_busy,
    input  wire [7:0] rewrite_addr_high,
    input  wire       rewrite_req,
    output reg        rewrite_grant,
    output reg        rewrite_refused
);
    wire [4:0] pin_raw;
    wire [4:0] pin_sync;
    wire      sclk_sync;
    wire      rxd_sync;
    wire      ce_sync;
    wire      epm_sync;
    wire      cnv_sync;
    reg       sclk_prev_reg;
    reg       rst_prev_reg;
    reg [4:0] hold_cnt_reg;
    reg [4:0] hold_cnt_next;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] rx_shift_reg;
    reg [2:0] rx_cnt_reg;
    reg [7:0] tx_shift_reg;
    reg [2:0] tx_cnt_reg;
    reg       tx_armed_reg;
    reg [2:0] id_idx_reg;
    reg       id_ok_reg;
    reg       id_ok_known_reg;
    reg       id_cmp_pend_reg;
    wire [7:0] id_rd_data;
    wire      sclk_rise;
    wire      sclk_fall;
    wire      byte_done;

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_READY = 3'h2;
    localparam [2:0] ST_XFER  = 3'h3;
    localparam [2:0] ST_EXEC  = 3'h4;

    // Shared by the receive and transmit bit counters
    function last_bit;
        input [2:0] cnt;
        begin
            last_bit = (cnt == `FSP_LAST_BIT);
        end
    endfunction

    function mode_is_serial;
        input [1:0] mode;
        begin
            mode_is_serial = (mode == `FSP_MODE_SERIAL);
        end
    endfunction

    // No reset on the synchronisers: pin levels must be settled by the release edge
    assign pin_raw = {processor_mode_pin, program_mode_select_in, chip_enable_in, serial_receive_in,
                      transfer_clock_in};
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_pin_sync
            reg [1:0] stage_reg;
            always @(posedge clock) begin
                stage_reg <= {stage_reg[0], pin_raw[g]};
            end
            // Only the second stage is read
            assign pin_sync[g] = stage_reg[1];
        end
    endgenerate
    assign sclk_sync = pin_sync[0];
    assign rxd_sync  = pin_sync[1];
    assign ce_sync   = pin_sync[2];
    assign epm_sync  = pin_sync[3];
    assign cnv_sync  = pin_sync[4];

    assign sclk_rise = sclk_sync & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_sync & sclk_prev_reg;
    assign byte_done = sclk_rise && last_bit(rx_cnt_reg);

    fsp_id_store u_id_store (
        .clock   (clock),
        .wr_en   (id_wr_en),
        .wr_addr (id_wr_addr),
        .wr_data (id_wr_data),
        .rd_addr (id_idx_reg),
        .rd_data (id_rd_data)
    );

    // Count clocks under reset; short hold is flagged, entry still taken
    always @* begin
        hold_cnt_next = hold_cnt_reg;
        if (!sys_rst) begin
            hold_cnt_next = 5'h00;
        end else if (hold_cnt_reg == `FSP_RESET_HOLD_CYC) begin
            hold_cnt_next = hold_cnt_reg;
        end else if (hold_cnt_reg < `FSP_RESET_HOLD_CYC) begin
            hold_cnt_next = hold_cnt_reg + 5'h01;
        end else begin
            // Unknown count at power-up restarts from one
            hold_cnt_next = 5'h01;
        end
    end

    // Mode is decided once, in the first cycle after release
    always @* begin
        mode_next = mode_reg;
        if (rst_prev_reg && !sys_rst) begin
            if (!cnv_sync) begin
                mode_next = `FSP_MODE_NORMAL;
            end else if (ce_sync && !epm_sync && boot_program_valid) begin
                mode_next = `FSP_MODE_SERIAL;
            end else begin
                mode_next = `FSP_MODE_IDLE;
            end
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (mode_is_serial(mode_reg)) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (sclk_fall) begin
                    state_next = ST_XFER;
                end
            end
            ST_XFER: begin
                if (byte_done) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (!exec_busy && !tx_armed_reg && !id_cmp_pend_reg) begin
                    state_next = ST_READY;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        sclk_prev_reg <= sclk_sync;
        rst_prev_reg  <= sys_rst;
        hold_cnt_reg  <= hold_cnt_next;
        if (rst_prev_reg && !sys_rst) begin
            reset_hold_short <= (hold_cnt_reg != `FSP_RESET_HOLD_CYC);
        end
        if (sys_rst) begin
            mode_reg            <= `FSP_MODE_IDLE;
            state_reg           <= ST_IDLE;
            rx_shift_reg        <= 8'h00;
            rx_cnt_reg          <= 3'h0;
            tx_shift_reg        <= 8'hFF;
            tx_cnt_reg          <= 3'h0;
            tx_armed_reg        <= 1'b0;
            id_idx_reg          <= 3'h0;
            id_ok_reg           <= 1'b1;
            id_ok_known_reg     <= 1'b0;
            id_cmp_pend_reg     <= 1'b0;
            serial_transmit_out <= 1'b1;
            serial_busy_out     <= 1'b1;
            serial_mode_active  <= 1'b0;
            normal_mode_active  <= 1'b0;
            rx_byte             <= 8'h00;
            rx_byte_valid       <= 1'b0;
            rx_is_id            <= 1'b0;
            cmd_rejected        <= 1'b0;
            id_matched          <= 1'b0;
            rewrite_grant       <= 1'b0;
            rewrite_refused     <= 1'b0;
        end else begin
            mode_reg           <= mode_next;
            state_reg          <= state_next;
            serial_mode_active <= mode_is_serial(mode_reg);
            normal_mode_active <= (mode_reg == `FSP_MODE_NORMAL);
            // Busy low only while ready; high from first edge through execution
            serial_busy_out    <= (state_next != ST_READY);
            rx_byte_valid      <= 1'b0;
            cmd_rejected       <= 1'b0;
            rewrite_grant      <= 1'b0;
            rewrite_refused    <= 1'b0;
            if (state_reg == ST_READY || state_reg == ST_XFER) begin
                if (sclk_rise) begin
                    rx_shift_reg <= {rxd_sync, rx_shift_reg[7:1]};
                    rx_cnt_reg   <= rx_cnt_reg + 3'h1;
                end
                if (sclk_fall) begin
                    if (tx_armed_reg) begin
                        serial_transmit_out <= tx_shift_reg[0];
                        tx_shift_reg        <= {1'b1, tx_shift_reg[7:1]};
                        tx_cnt_reg          <= tx_cnt_reg + 3'h1;
                        if (last_bit(tx_cnt_reg)) begin
                            tx_armed_reg <= 1'b0;
                        end
                    end else begin
                        // Nothing loaded: line rests high so the programmer reads all ones
                        serial_transmit_out <= 1'b1;
                    end
                end
            end
            if (tx_load && !tx_armed_reg) begin
                tx_shift_reg <= tx_byte;
                tx_cnt_reg   <= 3'h0;
                tx_armed_reg <= 1'b1;
            end
            if (byte_done) begin
                rx_cnt_reg <= 3'h0;
                if (id_idx_reg < `FSP_ID_BYTES && rx_is_id) begin
                    id_cmp_pend_reg <= 1'b1;
                end else if (!flash_blank && !(id_ok_known_reg && id_ok_reg)) begin
                    cmd_rejected <= 1'b1;
                end else begin
                    rx_byte_valid <= 1'b1;
                end
                rx_byte <= {rxd_sync, rx_shift_reg[7:1]};
            end
            // Stored byte is registered, compare one cycle after index set
            if (id_cmp_pend_reg) begin
                id_cmp_pend_reg <= 1'b0;
                if (rx_byte != id_rd_data) begin
                    id_ok_reg <= 1'b0;
                end
                if (id_idx_reg == `FSP_ID_BYTES - 3'h1) begin
                    rx_is_id        <= 1'b0;
                    id_ok_known_reg <= 1'b1;
                    id_matched      <= id_ok_reg && (rx_byte == id_rd_data);
                end
                id_idx_reg <= id_idx_reg + 3'h1;
            end
            if (id_check_start) begin
                rx_is_id        <= 1'b1;
                id_idx_reg      <= 3'h0;
                id_ok_reg       <= 1'b1;
                id_ok_known_reg <= 1'b0;
                id_matched      <= 1'b0;
            end
            if (rewrite_req) begin
                if (mode_is_serial(mode_reg) && rewrite_addr_high == `FSP_BOOT_AREA_HI) begin
                    rewrite_refused <= 1'b1;
                end else begin
                    rewrite_grant <= 1'b1;
                end
            end
        end
    end
    // Only four link signals are used; no other pin carries traffic
endmodule // fsp_serial_port

// ==== tb/fsp_checker.sv ====
// Purpose: Port assertions for fsp_serial_port.
// Assumes: Single clock domain, sync reset.
// Notes:   Boot area is rewrite_addr_high of FF.
module fsp_checker (
    input logic       clock,
    input logic       sys_rst,
    input logic       transfer_clock_in,
    input logic       exec_busy,
    input logic       flash_blank,
    input logic [7:0] rewrite_addr_high,
    input logic       rewrite_req,
    input logic       serial_busy_out,
    input logic       serial_mode_active,
    input logic       normal_mode_active,
    input logic       cmd_rejected,
    input logic       id_matched,
    input logic       rewrite_grant,
    input logic       rewrite_refused
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    sequence s_ready_fall;
        serial_mode_active && !serial_busy_out ##1 $fell(transfer_clock_in);
    endsequence
    // Reset must leave the port busy and modeless
    AST_RST_BUSY: assert property (sys_rst |=> serial_busy_out && !serial_mode_active && !normal_mode_active)
        else $error("busy or mode wrong during reset");
    AST_MODES_EXCL: assert property (disable iff (sys_rst) !(serial_mode_active && normal_mode_active))
        else $error("both modes active");
    AST_NORMAL_BUSY: assert property (disable iff (sys_rst) normal_mode_active |-> serial_busy_out)
        else $error("busy low in normal mode");
    AST_BUSY_RISE: assert property (disable iff (sys_rst) s_ready_fall |-> ##[1:6] serial_busy_out)
        else $error("busy did not rise after clock fall");
    AST_BUSY_FALL: assert property (disable iff (sys_rst) $fell(serial_busy_out) |-> !$past(exec_busy))
        else $error("busy fell while executing");
    AST_REJECT_GATE: assert property (disable iff (sys_rst)
        cmd_rejected |-> !$past(flash_blank) && !$past(id_matched))
        else $error("reject without gate cause");
    AST_REFUSE_BOOT: assert property (disable iff (sys_rst) serial_mode_active && rewrite_req &&
        rewrite_addr_high == 8'hFF |=> rewrite_refused && !rewrite_grant)
        else $error("boot rewrite not refused");
    AST_GRANT_USER: assert property (disable iff (sys_rst) serial_mode_active && rewrite_req &&
        rewrite_addr_high != 8'hFF |=> rewrite_grant && !rewrite_refused)
        else $error("user rewrite not granted");
endmodule // fsp_checker

bind fsp_serial_port fsp_checker u_chk (.clock, .sys_rst, .transfer_clock_in, .exec_busy, .flash_blank,
    .rewrite_addr_high, .rewrite_req, .serial_busy_out, .serial_mode_active, .normal_mode_active,
    .cmd_rejected, .id_matched, .rewrite_grant, .rewrite_refused);

// ==== tb/fsp_prog_model.sv ====
// Purpose: Programmer side of the serial link.
// Assumes: Bit time 400 ns, eight system clocks.
// Notes:   Moves on falling system clock edges.
module fsp_prog_model (
    input  logic clock,
    input  logic serial_busy_out,
    input  logic serial_transmit_out,
    output logic transfer_clock_in,
    output logic serial_receive_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        transfer_clock_in = 1'b1; // Programmer owns the clock, idle high
        serial_receive_in = 1'b1;
    end
    task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
        integer n;
        ok = 1'b0;
        for (n = 0; n < 400 && !ok; n++) begin
            @(negedge clock);
            ok = (serial_busy_out === 1'b0); // Next byte only after busy low
        end
        for (n = 0; n < 8 && ok; n++) begin
            transfer_clock_in = 1'b0;
            serial_receive_in = tx[n]; // Eight bits, LSB first
            repeat (4) @(negedge clock);
            transfer_clock_in = 1'b1;
            rx[n] = serial_transmit_out; // Read on rise, device shifted on fall
            repeat (4) @(negedge clock);
        end
        serial_receive_in = ~tx[7]; // No pull on the line, so idle must not look held
    endtask
endmodule // fsp_prog_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for fsp_serial_port.
// Assumes: 20 MHz clock, pins driven on falling edge.
// Notes:   Queue of received bytes is checked against the bytes sent.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic       chip_enable_in, program_mode_select_in, processor_mode_pin, boot_program_valid;
    logic       flash_blank, id_check_start, id_wr_en, tx_load, exec_busy, rewrite_req, ok;
    logic [2:0] id_wr_addr;
    logic [7:0] id_wr_data, tx_byte, rewrite_addr_high, got, rx_byte, q[$], idv[7];
    wire        transfer_clock_in, serial_receive_in;
    logic       serial_transmit_out, serial_busy_out, serial_mode_active, normal_mode_active;
    logic       reset_hold_short, rx_byte_valid, rx_is_id, cmd_rejected, id_matched, rewrite_grant;
    logic       rewrite_refused;
    integer     fail_count = 0, n_checks = 0, seed = 32'h16df, i, rej_n = 0;
    always #25 clock = ~clock;
    fsp_serial_port DUT (.clock, .sys_rst, .chip_enable_in, .program_mode_select_in, .processor_mode_pin,
        .boot_program_valid, .flash_blank, .transfer_clock_in, .serial_receive_in, .serial_transmit_out,
        .serial_busy_out, .serial_mode_active, .normal_mode_active, .reset_hold_short, .rx_byte, .rx_byte_valid,
        .rx_is_id, .cmd_rejected, .id_matched, .id_check_start, .id_wr_en, .id_wr_addr, .id_wr_data, .tx_byte,
        .tx_load, .exec_busy, .rewrite_addr_high, .rewrite_req, .rewrite_grant, .rewrite_refused);
    fsp_prog_model prog (.clock, .serial_busy_out, .serial_transmit_out, .transfer_clock_in, .serial_receive_in);
    always @(posedge clock) begin
        if (rx_byte_valid === 1'b1) q.push_back(rx_byte);
        if (cmd_rejected === 1'b1) rej_n++;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task send(input logic [7:0] b);
        prog.send_byte(b, got, ok);
        if (!ok) begin
            fail_count++;
            complete_run;
        end
        repeat (6) @(negedge clock);
    endtask
    task xfer(input logic [7:0] b, input logic acc, input logic [7:0] txe);
        integer r;
        r = rej_n;
        send(b);
        chk(8'(q.size()), {7'h0, acc});
        chk(8'(rej_n - r), {7'h0, !acc});
        if (q.size() > 0) chk(q.pop_front(), b);
        chk(got, txe);
        $display("Byte %h done", b);
    endtask
    task do_reset(input integer cyc);
        sys_rst = 1'b1;
        repeat (cyc) @(negedge clock);
        sys_rst = 1'b0;
        repeat (6) @(negedge clock);
    endtask
    initial begin
        {chip_enable_in, program_mode_select_in, processor_mode_pin, boot_program_valid} = 4'hB;
        {flash_blank, id_check_start, id_wr_en, tx_load, exec_busy, rewrite_req} = 6'h20;
        {id_wr_addr, id_wr_data, tx_byte, rewrite_addr_high} = 27'h0;
        do_reset(8);
        chk(reset_hold_short, 1'b1);
        for (i = 0; i < 17; i++) begin
            {chip_enable_in, program_mode_select_in, processor_mode_pin, boot_program_valid} = 4'(i % 16 ^ 11);
            do_reset(24); // Pins held across reset
            chk(serial_mode_active, i % 16 == 0);
            chk(normal_mode_active, !processor_mode_pin);
        end
        chk(reset_hold_short, 1'b0);
        chk(serial_busy_out, 1'b0);
        $display("Mode entry test done");
        for (i = 0; i < 6; i++) begin
            tx_byte = 8'($random(seed));
            tx_load = 1'b1;
            exec_busy = (i == 3);
            @(negedge clock);
            tx_load = 1'b0;
            xfer(8'($random(seed)), 1'b1, tx_byte);
            if (exec_busy) chk(serial_busy_out, 1'b1);
            exec_busy = 1'b0;
        end
        flash_blank = 1'b0;
        xfer(8'($random(seed)), 1'b0, 8'hFF);
        id_wr_en = 1'b1;
        for (i = 0; i < 7; i++) begin
            idv[i] = 8'($random(seed));
            id_wr_addr = 3'(i);
            id_wr_data = idv[i];
            @(negedge clock);
        end
        id_wr_en = 1'b0;
        id_check_start = 1'b1;
        @(negedge clock);
        id_check_start = 1'b0;
        chk(rx_is_id, 1'b1);
        for (i = 0; i < 7; i++) send(idv[i]);
        chk(id_matched, 1'b1);
        chk(rx_is_id, 1'b0);
        q.delete();
        xfer(8'($random(seed)), 1'b1, 8'hFF);
        $display("Gate test done");
        for (i = 0; i < 4; i++) begin
            rewrite_addr_high = i[0] ? 8'hFF : 8'($random(seed)) & 8'hFE;
            rewrite_req = 1'b1;
            @(negedge clock);
            rewrite_req = 1'b0;
            chk({rewrite_grant, rewrite_refused}, {!i[0], i[0]});
            @(negedge clock);
        end
        $display("Rewrite test done");
        complete_run;
    end
endmodule // tb_top
